// *** irq_prio_pkg.sv ***
// Purpose: Shared constants and types for the interrupt priority controller
// Assumes: 32-bit classic Wishbone register access, one clock domain
// Notes: Level registers sit at word indices; byte address is index * 4
package irq_prio_pkg;

  // ==========================================================
  // Sources and numbering
  localparam int NUM_SRC = 48;
  localparam int TREE_LEAVES = 64;
  localparam logic [5:0] NUM_BASE = 6'h10;
  localparam int SRC_IDX_W = 6;

  // Source slots of the named peripheral groups
  localparam int EXT_PIN_IRQ_ZERO_IDX = 2;
  localparam int EXT_PIN_COUNT = 3;
  localparam int SERIAL_CHAN_ZERO_IDX = 19;
  localparam int SERIAL_CHAN_COUNT = 3;
  localparam int SOFT_ADC_IDX = 22;
  localparam int KEY_INPUT_IDX = 23;

  // ==========================================================
  // Level field
  localparam int LEVEL_W = 5;
  localparam int LEVEL_FIELD_MSB = 4;
  localparam logic [LEVEL_W-1:0] LEVEL_DISABLED = 5'h1f;
  localparam logic [LEVEL_W-1:0] LEVEL_RESET = 5'h1f;

  // ==========================================================
  // Register map (word indices)
  localparam int IDX_W = 14;
  localparam logic [IDX_W-1:0] LEVEL_IDX_FIRST = 14'h0400;
  localparam logic [IDX_W-1:0] LEVEL_IDX_LAST = 14'h042f;
  localparam logic [IDX_W-1:0] WINNER_IDX = 14'h0430;
  localparam logic [IDX_W-1:0] GROUP_IDX = 14'h0431;

  // Winner status word layout
  localparam int ST_VALID_BIT = 31;
  localparam int ST_OFFS_LSB = 16;
  localparam int ST_NUM_LSB = 8;

  // ==========================================================
  // Vector table
  localparam int OFFS_W = 10;
  localparam logic [OFFS_W-1:0] VECTOR_OFFS_TOP = 10'h3fc;
  localparam logic [31:0] VECTOR_TABLE_BASE_RESET = 32'h000f_fc00;

  // Candidate carried through the priority tree
  typedef struct packed {
    logic valid;
    logic [LEVEL_W-1:0] level;
    logic [SRC_IDX_W-1:0] number;
  } cand_t;

  localparam cand_t CAND_NONE = '{valid: 1'b0, level: LEVEL_DISABLED,
                                  number: 6'h00};

endpackage

// *** priority_pick.sv ***
// Purpose: One comparison node of the priority tree
// Assumes: Input a always carries the smaller interrupt numbers than b
// Notes: Purely combinational
`timescale 1ns/1ps
`default_nettype none
module priority_pick (
  input wire irq_prio_pkg::cand_t a_i,
  input wire irq_prio_pkg::cand_t b_i,
  output irq_prio_pkg::cand_t win_o
);

  wire a_wins;

  // ties go to a, the smaller number
  assign a_wins = a_i.valid && (!b_i.valid || (a_i.level <= b_i.level));
  assign win_o = a_wins ? a_i : b_i;

endmodule
`default_nettype wire

// *** irq_priority_controller.sv ***
// Purpose: 48-source interrupt priority controller with level registers
// Assumes: Request lines come from peripheral logic on clk_i
// Notes: Winner is re-evaluated every cycle and registered once
`timescale 1ns/1ps
`default_nettype none
// Operation
// - one five-bit level register per source
// - level top bit always one, 16..31
// - level 16 highest, larger is lower
// - level 31 excludes source from selection
// - lowest level among active requests wins
// - equal levels: smallest interrupt number wins
// - present winner level and number to core
// - external pins on IRQ2..4, numbers 18..20
// - vector offset is 0x3FC minus 4n
// - serial channels on IRQ19..21, numbers 35..37
// - soft converter IRQ22, key input IRQ23
// - wake-up is OR of all requests
module irq_priority_controller (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [15:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  input wire logic [irq_prio_pkg::NUM_SRC-1:0] irq_req_i,
  output logic irq_valid_o,
  output logic [irq_prio_pkg::LEVEL_W-1:0] irq_level_o,
  output logic [irq_prio_pkg::SRC_IDX_W-1:0] irq_number_o,
  output logic [irq_prio_pkg::OFFS_W-1:0] vector_offset_o,
  output logic [31:0] vector_addr_o,
  output logic wake_o
);

  // ==========================================================
  // Bus decode
  logic ack_reg;
  logic [31:0] dat_reg;
  logic [31:0] rd_next;
  wire req_new;
  wire wr_strobe;
  wire [irq_prio_pkg::IDX_W-1:0] word_idx;
  wire level_hit;
  wire winner_hit;
  wire group_hit;
  wire [irq_prio_pkg::IDX_W-1:0] level_rel;
  wire [irq_prio_pkg::SRC_IDX_W-1:0] level_sel;

  assign req_new = cyc_i && stb_i && !ack_reg;
  assign wr_strobe = req_new && we_i && sel_i[0];
  assign word_idx = adr_i[15:2];
  assign level_hit = (word_idx >= irq_prio_pkg::LEVEL_IDX_FIRST) &&
                     (word_idx <= irq_prio_pkg::LEVEL_IDX_LAST);
  assign winner_hit = (word_idx == irq_prio_pkg::WINNER_IDX);
  assign group_hit = (word_idx == irq_prio_pkg::GROUP_IDX);
  assign level_rel = word_idx - irq_prio_pkg::LEVEL_IDX_FIRST;
  assign level_sel = level_rel[irq_prio_pkg::SRC_IDX_W-1:0];

  // ==========================================================
  // Level registers
  logic [irq_prio_pkg::LEVEL_W-1:0] level_reg [irq_prio_pkg::NUM_SRC];
  irq_prio_pkg::cand_t tree [1:2*irq_prio_pkg::TREE_LEAVES-1];

  genvar g;
  generate
    for (g = 0; g < irq_prio_pkg::NUM_SRC; g++) begin : gen_src
      wire hit_this;
      wire [irq_prio_pkg::SRC_IDX_W-1:0] num_this;

      assign hit_this = wr_strobe && level_hit &&
                        (level_sel == irq_prio_pkg::SRC_IDX_W'(g));
      assign num_this = irq_prio_pkg::SRC_IDX_W'(g) + irq_prio_pkg::NUM_BASE;

      always_ff @(posedge clk_i) begin
        if (rst_i) begin
          level_reg[g] <= irq_prio_pkg::LEVEL_RESET;
        end else if (hit_this) begin
          level_reg[g] <= {1'b1, dat_i[irq_prio_pkg::LEVEL_FIELD_MSB-1:0]};
        end
      end

      // level 31 never becomes a candidate
      // level value carried as priority key
      assign tree[irq_prio_pkg::TREE_LEAVES+g] = '{
        valid: irq_req_i[g] &&
               (level_reg[g] != irq_prio_pkg::LEVEL_DISABLED),
        level: level_reg[g],
        number: num_this};
    end

    for (g = irq_prio_pkg::NUM_SRC; g < irq_prio_pkg::TREE_LEAVES;
         g++) begin : gen_pad
      assign tree[irq_prio_pkg::TREE_LEAVES+g] = irq_prio_pkg::CAND_NONE;
    end

    // Heap-ordered tree keeps lower numbers on the left input
    for (g = 1; g < irq_prio_pkg::TREE_LEAVES; g++) begin : gen_node
      priority_pick u_pick (
        .a_i(tree[2*g]),
        .b_i(tree[2*g+1]),
        .win_o(tree[g])
      );
    end
  endgenerate

  // ==========================================================
  // Winner and vector
  irq_prio_pkg::cand_t win;
  wire [irq_prio_pkg::OFFS_W-1:0] offs_next;
  wire [31:0] addr_next;
  logic valid_reg;
  logic [irq_prio_pkg::LEVEL_W-1:0] level_out_reg;
  logic [irq_prio_pkg::SRC_IDX_W-1:0] number_reg;
  logic [irq_prio_pkg::OFFS_W-1:0] offs_reg;
  logic [31:0] addr_reg;
  logic wake_reg;

  // idle output shows level 31, number 0
  assign win = tree[1].valid ? tree[1] : irq_prio_pkg::CAND_NONE;
  // offset is 0x3FC minus four times number
  assign offs_next = irq_prio_pkg::VECTOR_OFFS_TOP -
                     {2'b00, win.number, 2'b00};
  assign addr_next = irq_prio_pkg::VECTOR_TABLE_BASE_RESET +
                     {22'h00_0000, offs_next};

  // winner level and number registered out
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      valid_reg <= 1'b0;
      level_out_reg <= irq_prio_pkg::LEVEL_DISABLED;
      number_reg <= '0;
      offs_reg <= irq_prio_pkg::VECTOR_OFFS_TOP;
      addr_reg <= irq_prio_pkg::VECTOR_TABLE_BASE_RESET;
    end else begin
      valid_reg <= win.valid;
      level_out_reg <= win.level;
      number_reg <= win.number;
      offs_reg <= win.valid ? offs_next : irq_prio_pkg::VECTOR_OFFS_TOP;
      addr_reg <= win.valid ? addr_next :
                  irq_prio_pkg::VECTOR_TABLE_BASE_RESET;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wake_reg <= 1'b0;
    end else begin
      wake_reg <= |irq_req_i;
    end
  end

  // ==========================================================
  // Group pending view
  wire [7:0] group_pending;

  assign group_pending[2:0] =
    irq_req_i[irq_prio_pkg::EXT_PIN_IRQ_ZERO_IDX +:
              irq_prio_pkg::EXT_PIN_COUNT];
  assign group_pending[5:3] =
    irq_req_i[irq_prio_pkg::SERIAL_CHAN_ZERO_IDX +:
              irq_prio_pkg::SERIAL_CHAN_COUNT];
  assign group_pending[6] = irq_req_i[irq_prio_pkg::SOFT_ADC_IDX];
  assign group_pending[7] = irq_req_i[irq_prio_pkg::KEY_INPUT_IDX];

  // ==========================================================
  // Read mux and acknowledge
  always_comb begin
    rd_next = 32'h0000_0000;
    if (level_hit) begin
      rd_next[irq_prio_pkg::LEVEL_W-1:0] = level_reg[level_sel];
    end else if (winner_hit) begin
      rd_next[irq_prio_pkg::ST_VALID_BIT] = valid_reg;
      rd_next[irq_prio_pkg::ST_OFFS_LSB +: irq_prio_pkg::OFFS_W] =
        offs_reg;
      rd_next[irq_prio_pkg::ST_NUM_LSB +: irq_prio_pkg::SRC_IDX_W] =
        number_reg;
      rd_next[irq_prio_pkg::LEVEL_W-1:0] = level_out_reg;
    end else if (group_hit) begin
      rd_next[7:0] = group_pending;
    end
  end

  // One-cycle ack; unmapped words read zero and ignore writes
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_reg <= 1'b0;
      dat_reg <= 32'h0000_0000;
    end else begin
      ack_reg <= req_new;
      dat_reg <= (req_new && !we_i) ? rd_next : 32'h0000_0000;
    end
  end

  assign ack_o = ack_reg;
  assign dat_o = dat_reg;
  assign irq_valid_o = valid_reg;
  assign irq_level_o = level_out_reg;
  assign irq_number_o = number_reg;
  assign vector_offset_o = offs_reg;
  assign vector_addr_o = addr_reg;
  assign wake_o = wake_reg;

endmodule
`default_nettype wire

// *** irq_prio_assertions.sv ***
// Purpose: Port checks for the interrupt priority controller
// Assumes: Bound to the top module, one clock domain
// Notes: req_reg mirrors the one-cycle winner latency
`timescale 1ns/1ps
`default_nettype none
module irq_prio_assertions (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic [31:0] dat_o,
  input wire logic ack_o,
  input wire logic [47:0] irq_req_i,
  input wire logic irq_valid_o,
  input wire logic [4:0] irq_level_o,
  input wire logic [5:0] irq_number_o,
  input wire logic [9:0] vector_offset_o,
  input wire logic [31:0] vector_addr_o,
  input wire logic wake_o
);
  logic [47:0] req_reg;
  logic rst_reg;
  always_ff @(posedge clk_i) begin
    req_reg <= irq_req_i;
    rst_reg <= rst_i;
  end
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // ==========================================
  // Winner and bus relations
  property p_idle; !irq_valid_o |-> irq_level_o == 5'h1f; endproperty
  a_idle: assert property (p_idle) else $error("idle level");
  property p_offs;
    vector_offset_o == 10'h3fc - {2'b00, irq_number_o, 2'b00};
  endproperty
  a_offs: assert property (p_offs) else $error("offset");
  // Idle output holds the bare table base, not base plus offset
  property p_addr;
    vector_addr_o == (irq_valid_o ?
      32'h000f_fc00 + {22'h00_0000, vector_offset_o} : 32'h000f_fc00);
  endproperty
  a_addr: assert property (p_addr) else $error("address");
  property p_wake; !rst_reg |-> wake_o == |req_reg; endproperty
  a_wake: assert property (p_wake) else $error("wake");
  property p_src;
    irq_valid_o && !rst_reg |-> req_reg[irq_number_o - 6'h10];
  endproperty
  a_src: assert property (p_src) else $error("source idle");
  property p_lvl;
    irq_valid_o |-> irq_level_o[4] && irq_level_o != 5'h1f;
  endproperty
  a_lvl: assert property (p_lvl) else $error("level");
  property p_ack; cyc_i && stb_i && !ack_o |=> ack_o ##1 !ack_o; endproperty
  a_ack: assert property (p_ack) else $error("ack");
  property p_dat; !ack_o |-> dat_o == 32'h0000_0000; endproperty
  a_dat: assert property (p_dat) else $error("data");
  c_win: cover property (irq_valid_o ##1 !irq_valid_o);
  c_ack: cover property (ack_o);
  c_wake: cover property (wake_o && !irq_valid_o);
endmodule
`default_nettype wire

// *** cpu_core_model.sv ***
// Purpose: CPU core that accepts or masks the presented winner
// Assumes: Mask value comes from the bench
// Notes: Combinational accept decision
`timescale 1ns/1ps
`default_nettype none
module cpu_core_model (
  input wire logic valid_i,
  input wire logic [4:0] level_i,
  input wire logic [4:0] mask_i,
  output logic take_o
);
  assign take_o = valid_i && (level_i < mask_i);
endmodule
`default_nettype wire

// *** testbench.sv ***
// Purpose: Self-checking bench for the interrupt priority controller
// Assumes: Requests arrive already gated and synchronous
// Notes: Read data is checked against a queue of expectations
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cyc, stb, we, ack_o, v, wake, take;
  logic [3:0] sel;
  logic [15:0] adr;
  logic [31:0] dat, dat_o, e;
  logic [4:0] lvl, mask;
  logic [5:0] num;
  logic [9:0] offs;
  logic [31:0] vad;
  logic [47:0] req;
  logic [4:0] lv [48];
  logic [31:0] q [$];
  int fails = 0;
  int checked = 0;
  always #5 clk_i = ~clk_i;
  irq_priority_controller dut (.clk_i, .rst_i, .cyc_i(cyc), .stb_i(stb),
    .we_i(we), .adr_i(adr), .sel_i(sel), .dat_i(dat), .dat_o, .ack_o,
    .irq_req_i(req), .irq_valid_o(v), .irq_level_o(lvl),
    .irq_number_o(num), .vector_offset_o(offs), .vector_addr_o(vad),
    .wake_o(wake));
  cpu_core_model u_cpu (.valid_i(v), .level_i(lvl), .mask_i(mask),
    .take_o(take));
  // ==========================================
  // Tasks
  task automatic check(input logic [31:0] s, input logic [31:0] x);
    checked++;
    if (s !== x) begin
      fails++;
      $display("[ERR] %0t got %h want %h", $time, s, x);
    end
  endtask
  task automatic stop_test;
    $display("checks %0d mismatches %0d", checked, fails);
    if (fails == 0 && checked > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  task automatic bus(input logic w, input logic [15:0] a,
                     input logic [31:0] d, input logic [3:0] s);
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    dat <= d;
    sel <= s;
    do @(posedge clk_i); while (ack_o !== 1'b1);
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask
  task automatic rd(input logic [15:0] a, input logic [31:0] x);
    q.push_back(x);
    bus(1'b0, a, '0, 4'hf);
  endtask
  task automatic wl(input int k, input logic [31:0] d);
    lv[k] = {1'b1, d[3:0]};
    bus(1'b1, 16'h1000 + 16'(k * 4), d, 4'hf);
  endtask
  function automatic logic [31:0] ew(input logic [47:0] r);
    logic [4:0] bl;
    logic [5:0] bn;
    logic ok;
    ok = 1'b0;
    bl = 5'h1f;
    bn = 6'h00;
    for (int k = 0; k < 48; k++)
      if (r[k] && lv[k] != 5'h1f && (!ok || lv[k] < bl)) begin
        ok = 1'b1;
        bl = lv[k];
        bn = 6'(k + 16);
      end
    return {ok, 5'h00, 10'h3fc - {bn, 2'b00}, 2'h0, bn, 3'h0, bl};
  endfunction
  always @(posedge clk_i)
    if (ack_o === 1'b1 && we === 1'b0 && q.size() > 0)
      check(dat_o, q.pop_front());
  initial begin
    #200_000;
    fails++;
    stop_test();
  end
  // ==========================================
  // Main sequence
  initial begin
    {cyc, stb, we, sel, adr, dat, req, mask} = '0;
    for (int k = 0; k < 48; k++) lv[k] = 5'h1f;
    void'($urandom(9029));
    repeat (5) @(posedge clk_i);
    rst_i <= 1'b0;
    rd(16'h1000, 32'h0000_001f);
    check({20'h0_0000, v, lvl, num}, 32'h0000_07c0);
    check(vad, 32'h000f_fc00);
    check({31'h0000_0000, wake}, 32'h0000_0000);
    rd(16'h10bc, 32'h0000_001f);
    rd(16'h10c0, 32'h03fc_001f);
    rd(16'h2000, '0);
    bus(1'b1, 16'h1014, '0, 4'h0);
    rd(16'h1014, 32'h0000_001f);
    wl(5, 32'h0000_0004);
    req <= 48'h0000_0000_0020;
    repeat (2) @(posedge clk_i);
    rd(16'h10c0, 32'h83a8_1514);
    check(vad, 32'h000f_ffa8);
    wl(5, '0);
    rd(16'h1014, 32'h0000_0010);
    wl(3, '0);
    req <= 48'h0000_0000_0028;
    bus(1'b1, 16'h10c0, '0, 4'hf);
    rd(16'h10c0, ew(48'h0000_0000_0028));
    wl(3, 32'h0000_0001);
    rd(16'h10c0, ew(48'h0000_0000_0028));
    wl(5, 32'h0000_000f);
    rd(16'h10c0, ew(48'h0000_0000_0028));
    $display("directed tests done");
    for (int i = 0; i < 6; i++) begin
      for (int k = 0; k < 48; k++) wl(k, $urandom);
      req <= {16'($urandom), $urandom};
      mask <= 5'($urandom);
      repeat (2) @(posedge clk_i);
      e = ew(req);
      check({31'h0000_0000, take}, {31'h0, e[31] && e[4:0] < mask});
      check({26'h000_0000, num}, {26'h000_0000, e[13:8]});
      check({27'h000_0000, lvl}, {27'h000_0000, e[4:0]});
      check(vad, e[31] ? 32'h000f_fc00 + {22'h00_0000, e[25:16]} :
            32'h000f_fc00);
      check({31'h0000_0000, wake}, {31'h0000_0000, |req});
      rd(16'h10c0, ew(req));
      rd(16'h10c4, {24'h00_0000, req[23:19], req[4:2]});
    end
    for (int k = 0; k < 48; k++) wl(k, 32'h0000_000f);
    req <= '1;
    repeat (2) @(posedge clk_i);
    check({31'h0000_0000, wake}, 32'h0000_0001);
    rd(16'h10c0, 32'h03fc_001f);
    $display("random tests done");
    stop_test();
  end
endmodule
bind irq_priority_controller irq_prio_assertions u_chk (.clk_i, .rst_i,
  .cyc_i, .stb_i, .dat_o, .ack_o, .irq_req_i, .irq_valid_o, .irq_level_o,
  .irq_number_o, .vector_offset_o, .vector_addr_o, .wake_o);
`default_nettype wire
